// *** hdl/ufdc_defs.svh ***
// Register offsets, field positions and reset values of the USB function control block
`ifndef UFDC_DEFS_SVH
`define UFDC_DEFS_SVH
`define UFDC_A_FUNCTION_ADDRESS 6'h00
`define UFDC_A_POWER 6'h01
`define UFDC_A_INFLG 6'h02
`define UFDC_A_OUTFLG 6'h04
`define UFDC_A_CMFLG 6'h06
`define UFDC_A_INEN 6'h07
`define UFDC_A_OUTEN 6'h09
`define UFDC_A_CMEN 6'h0b
`define UFDC_A_FRML 6'h0c
`define UFDC_A_FRMH 6'h0d
`define UFDC_A_INDEX 6'h0e
`define UFDC_A_FIFO 4'h8
`define UFDC_POWER_RST 8'h10
`define UFDC_INEN_RST 4'hf
`define UFDC_OUTEN_RST 4'he
`define UFDC_CMEN_RST 4'h6
`define UFDC_PW_ISO 7
`define UFDC_PW_INH 4
`define UFDC_PW_RST 3
`define UFDC_PW_RES 2
`define UFDC_PW_SEN 0
`define UFDC_CM_SOF 3
`define UFDC_CM_RST 2
`define UFDC_CM_RSU 1
`define UFDC_CM_SUS 0
`define UFDC_SFR_BUSY 7
`define UFDC_SFR_AUTO 6
`define UFDC_EP_UNIT 10'h040
`endif

// *** hdl/ufdc_pkg.sv ***
// Types shared by the USB function control block
package ufdc_pkg;
  typedef logic [7:0] ufdc_byte_t;
  typedef logic [8:0] ufdc_ptr_t;
  typedef logic [9:0] ufdc_addr_t;
  typedef enum logic [1:0] {
    UFDC_EP0 = 2'b00,
    UFDC_EP1 = 2'b01,
    UFDC_EP2 = 2'b10,
    UFDC_EP3 = 2'b11
  } ufdc_ep_e;
endpackage

// *** hdl/ufdc_core.sv ***
// USB function device control: indirect register port, endpoint buffers, power and interrupt flags
`timescale 1ns/10ps
`default_nettype none
`include "ufdc_defs.svh"

module ufdc_core
  import ufdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sfrSel,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata_q,
  input wire logic cpuIrqEn,
  output logic irq_q,
  input wire logic busResetDet,
  input wire logic suspendDet,
  input wire logic resumeDet,
  input wire logic sofRx,
  input wire logic [10:0] sofFrame,
  input wire logic xferEnd,
  input wire logic inToken,
  input wire logic [1:0] tokenEp,
  input wire logic [3:0] isoEp,
  input wire logic [3:0] inPktLoaded,
  input wire logic [3:0] inEpDone,
  input wire logic [3:0] outEpDone,
  input wire logic [3:0] splitMode,
  input wire logic sieWr,
  input wire logic [1:0] sieWrEp,
  input wire logic [7:0] sieWrData,
  input wire logic sieRd,
  input wire logic [1:0] sieRdEp,
  output logic [7:0] sieRdData_q,
  output logic [6:0] activeAddr_q,
  output logic coreInhibit_q,
  output logic resumeDrive_q,
  output logic suspendActive_q,
  output logic zlpSend_q,
  output logic [3:0] isoHold_q
);

  // Buffer byte address from endpoint, half and offset
  function automatic ufdc_addr_t bufAddr(input logic [1:0] ep, input logic split, input logic inHalf,
                                         input ufdc_ptr_t off);
    ufdc_addr_t size;
    ufdc_addr_t area;
    ufdc_addr_t base;
    size = (ep == UFDC_EP0) ? `UFDC_EP_UNIT : ufdc_addr_t'(`UFDC_EP_UNIT << ep);
    base = ufdc_addr_t'(`UFDC_EP_UNIT * ((10'h001 << ep) - 10'h001));
    area = (split && ep != UFDC_EP0) ? (size >> 1) : size;
    if (split && inHalf && ep != UFDC_EP0) begin
      base = base + area;
    end
    bufAddr = base + ({1'b0, off} & (area - 10'h001));
  endfunction

  ufdc_byte_t mem [0:1023];

  // ==========================================================
  // Indirect access ports
  logic [5:0] sfrAddr_q, sfrAddr_d;
  logic autoRd_q, autoRd_d, busy_q, busy_d, swRst_q, swRst_d;
  ufdc_byte_t data_q, data_d, sfrRdata_d, rdByte;
  logic coreRd, coreWr, coreRst_n;

  always_comb begin
    coreRd = 1'b0;
    coreWr = 1'b0;
    sfrAddr_d = sfrAddr_q;
    autoRd_d = autoRd_q;
    busy_d = 1'b0;
    data_d = data_q;
    sfrRdata_d = sfrRdata_q;
    swRst_d = 1'b0;
    if (sfrWr && !sfrSel) begin
      sfrAddr_d = sfrWdata[5:0];
      autoRd_d = sfrWdata[`UFDC_SFR_AUTO];
      busy_d = sfrWdata[`UFDC_SFR_BUSY];
    end else if (sfrWr && sfrSel) begin
      coreWr = 1'b1;
      swRst_d = (sfrAddr_q == `UFDC_A_POWER) && sfrWdata[`UFDC_PW_RST];
    end
    if (sfrRd) begin
      sfrRdata_d = sfrSel ? data_q : {busy_q, autoRd_q, sfrAddr_q};
    end
    if (sfrRd && sfrSel && autoRd_q) begin
      busy_d = 1'b1;
    end
    if (busy_q) begin
      coreRd = 1'b1;
      data_d = rdByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrAddr_q <= 6'h00;
      autoRd_q <= 1'b0;
      busy_q <= 1'b0;
      data_q <= 8'h00;
      sfrRdata_q <= 8'h00;
      swRst_q <= 1'b0;
    end else begin
      sfrAddr_q <= sfrAddr_d;
      autoRd_q <= autoRd_d;
      busy_q <= busy_d;
      data_q <= data_d;
      sfrRdata_q <= sfrRdata_d;
      swRst_q <= swRst_d;
    end
  end

  assign coreRst_n = rst_n & ~swRst_q;

  // ==========================================================
  // Core registers and endpoint pointers
  ufdc_byte_t function_address_q, function_address_d, index_q, index_d, sieRdData_d;
  logic [6:0] actAddr_d;
  logic iso_hold_until_sof_q, iso_hold_until_sof_d, inh_d, res_d, sus_d, suspend_detect_en_q, suspend_detect_en_d, rstPrev_q, rstPrev_d, zlp_d, irq_d;
  logic [3:0] inFlg_q, inFlg_d, outFlg_q, outFlg_d, cmFlg_q, cmFlg_d;
  logic [3:0] inEn_q, inEn_d, outEn_q, outEn_d, cmEn_q, cmEn_d, isoWait_d;
  logic [10:0] frame_q, frame_d;
  ufdc_ptr_t cpuWr_q [4], cpuWr_d [4], cpuRd_q [4], cpuRd_d [4];
  ufdc_ptr_t sieWp_q [4], sieWp_d [4], sieRp_q [4], sieRp_d [4];
  logic busRst, memCpuWe;
  logic [1:0] fep;
  ufdc_addr_t cpuWa, sieWa;

  assign fep = sfrAddr_q[1:0];
  assign memCpuWe = coreWr && (sfrAddr_q[5:2] == `UFDC_A_FIFO);
  assign cpuWa = bufAddr(fep, splitMode[fep], 1'b1, cpuWr_q[fep]);
  assign sieWa = bufAddr(sieWrEp, splitMode[sieWrEp], 1'b0, sieWp_q[sieWrEp]);
  assign busRst = busResetDet && !rstPrev_q && !coreInhibit_q;

  always_comb begin
    if (sfrAddr_q == `UFDC_A_FUNCTION_ADDRESS) begin
      rdByte = function_address_q;
    end else if (sfrAddr_q == `UFDC_A_POWER) begin
      rdByte = {iso_hold_until_sof_q, 2'b00, coreInhibit_q, busResetDet, resumeDrive_q, suspendActive_q, suspend_detect_en_q};
    end else if (sfrAddr_q == `UFDC_A_INFLG) begin
      rdByte = {4'h0, inFlg_q};
    end else if (sfrAddr_q == `UFDC_A_OUTFLG) begin
      rdByte = {4'h0, outFlg_q[3:1], 1'b0};
    end else if (sfrAddr_q == `UFDC_A_CMFLG) begin
      rdByte = {4'h0, cmFlg_q};
    end else if (sfrAddr_q == `UFDC_A_INEN) begin
      rdByte = {4'h0, inEn_q};
    end else if (sfrAddr_q == `UFDC_A_OUTEN) begin
      rdByte = {4'h0, outEn_q[3:1], 1'b0};
    end else if (sfrAddr_q == `UFDC_A_CMEN) begin
      rdByte = {4'h0, cmEn_q};
    end else if (sfrAddr_q == `UFDC_A_FRML) begin
      rdByte = frame_q[7:0];
    end else if (sfrAddr_q == `UFDC_A_FRMH) begin
      rdByte = {5'h00, frame_q[10:8]};
    end else if (sfrAddr_q == `UFDC_A_INDEX) begin
      rdByte = index_q;
    end else if (sfrAddr_q[5:2] == `UFDC_A_FIFO) begin
      rdByte = mem[bufAddr(fep, splitMode[fep], 1'b0, cpuRd_q[fep])];
    end else begin
      rdByte = 8'h00;
    end
  end

  always_comb begin
    function_address_d = function_address_q;
    actAddr_d = activeAddr_q;
    index_d = index_q;
    iso_hold_until_sof_d = iso_hold_until_sof_q;
    inh_d = coreInhibit_q;
    res_d = resumeDrive_q;
    sus_d = suspendActive_q;
    suspend_detect_en_d = suspend_detect_en_q;
    inFlg_d = inFlg_q;
    outFlg_d = outFlg_q;
    cmFlg_d = cmFlg_q;
    inEn_d = inEn_q;
    outEn_d = outEn_q;
    cmEn_d = cmEn_q;
    frame_d = frame_q;
    isoWait_d = isoHold_q;
    rstPrev_d = busResetDet;
    cpuWr_d = cpuWr_q;
    cpuRd_d = cpuRd_q;
    sieWp_d = sieWp_q;
    sieRp_d = sieRp_q;
    sieRdData_d = sieRdData_q;
    zlp_d = 1'b0;
    if (coreRd) begin
      if (sfrAddr_q == `UFDC_A_INFLG) begin
        inFlg_d = 4'h0;
      end else if (sfrAddr_q == `UFDC_A_OUTFLG) begin
        outFlg_d = 4'h0;
      end else if (sfrAddr_q == `UFDC_A_CMFLG) begin
        cmFlg_d = 4'h0;
      end else if (sfrAddr_q[5:2] == `UFDC_A_FIFO) begin
        cpuRd_d[fep] = cpuRd_q[fep] + 9'h001;
      end
    end
    if (xferEnd && function_address_q[7] && !coreInhibit_q) begin
      actAddr_d = function_address_q[6:0];
      function_address_d[7] = 1'b0;
    end
    if (coreWr) begin
      if (sfrAddr_q == `UFDC_A_FUNCTION_ADDRESS) begin
        function_address_d = {1'b1, sfrWdata[6:0]};
      end else if (sfrAddr_q == `UFDC_A_POWER) begin
        iso_hold_until_sof_d = sfrWdata[`UFDC_PW_ISO];
        inh_d = coreInhibit_q & sfrWdata[`UFDC_PW_INH];
        res_d = sfrWdata[`UFDC_PW_RES];
        suspend_detect_en_d = sfrWdata[`UFDC_PW_SEN];
        if (resumeDrive_q && !sfrWdata[`UFDC_PW_RES]) begin
          sus_d = 1'b0;
        end
      end else if (sfrAddr_q == `UFDC_A_INDEX) begin
        index_d = sfrWdata;
      end else if (sfrAddr_q == `UFDC_A_INEN) begin
        inEn_d = sfrWdata[3:0];
      end else if (sfrAddr_q == `UFDC_A_OUTEN) begin
        outEn_d = {sfrWdata[3:1], 1'b0};
      end else if (sfrAddr_q == `UFDC_A_CMEN) begin
        cmEn_d = sfrWdata[3:0];
      end else if (memCpuWe) begin
        cpuWr_d[fep] = cpuWr_q[fep] + 9'h001;
      end
    end
    if (!coreInhibit_q) begin
      if (suspend_detect_en_q && suspendDet && !suspendActive_q) begin
        sus_d = 1'b1;
        cmFlg_d[`UFDC_CM_SUS] = cmFlg_d[`UFDC_CM_SUS] | cmEn_q[`UFDC_CM_SUS];
      end
      if (resumeDet && suspendActive_q) begin
        sus_d = 1'b0;
        cmFlg_d[`UFDC_CM_RSU] = cmFlg_d[`UFDC_CM_RSU] | cmEn_q[`UFDC_CM_RSU];
      end
      if (sofRx) begin
        frame_d = sofFrame;
        isoWait_d = 4'h0;
        cmFlg_d[`UFDC_CM_SOF] = cmFlg_d[`UFDC_CM_SOF] | cmEn_q[`UFDC_CM_SOF];
      end
      isoWait_d = isoWait_d | (inPktLoaded & isoEp & {4{iso_hold_until_sof_q}});
      zlp_d = inToken && iso_hold_until_sof_q && isoEp[tokenEp] && isoHold_q[tokenEp];
      inFlg_d = inFlg_d | (inEpDone & inEn_q);
      outFlg_d = outFlg_d | (outEpDone & outEn_q & 4'he);
      if (sieWr) begin
        sieWp_d[sieWrEp] = sieWp_q[sieWrEp] + 9'h001;
      end
      if (sieRd) begin
        sieRp_d[sieRdEp] = sieRp_q[sieRdEp] + 9'h001;
        sieRdData_d = mem[bufAddr(sieRdEp, splitMode[sieRdEp], 1'b1, sieRp_q[sieRdEp])];
      end
    end
    if (busRst) begin
      function_address_d = 8'h00;
      actAddr_d = 7'h00;
      index_d = 8'h00;
      sus_d = 1'b0;
      for (int i = 0; i < 4; i++) begin
        cpuWr_d[i] = 9'h000;
        cpuRd_d[i] = 9'h000;
        sieWp_d[i] = 9'h000;
        sieRp_d[i] = 9'h000;
      end
      inEn_d = `UFDC_INEN_RST;
      outEn_d = `UFDC_OUTEN_RST;
      cmEn_d = {3'b111, cmEn_d[`UFDC_CM_SUS]};
      inFlg_d = 4'h0;
      outFlg_d = 4'h0;
      cmFlg_d = {2'b01, 1'b0, cmFlg_d[`UFDC_CM_SUS]};
    end
    irq_d = cpuIrqEn && (|{inFlg_d, outFlg_d, cmFlg_d});
  end

  always_ff @(posedge clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      function_address_q <= 8'h00;
      activeAddr_q <= 7'h00;
      index_q <= 8'h00;
      {iso_hold_until_sof_q, coreInhibit_q, resumeDrive_q, suspendActive_q, suspend_detect_en_q} <= 5'b01000;
      inFlg_q <= 4'h0;
      outFlg_q <= 4'h0;
      cmFlg_q <= 4'h0;
      inEn_q <= `UFDC_INEN_RST;
      outEn_q <= `UFDC_OUTEN_RST;
      cmEn_q <= `UFDC_CMEN_RST;
      frame_q <= 11'h000;
      isoHold_q <= 4'h0;
      rstPrev_q <= 1'b0;
      sieRdData_q <= 8'h00;
      zlpSend_q <= 1'b0;
      irq_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cpuWr_q[i] <= 9'h000;
        cpuRd_q[i] <= 9'h000;
        sieWp_q[i] <= 9'h000;
        sieRp_q[i] <= 9'h000;
      end
    end else begin
      function_address_q <= function_address_d;
      activeAddr_q <= actAddr_d;
      index_q <= index_d;
      {iso_hold_until_sof_q, coreInhibit_q, resumeDrive_q, suspendActive_q, suspend_detect_en_q} <= {iso_hold_until_sof_d, inh_d, res_d, sus_d, suspend_detect_en_d};
      inFlg_q <= inFlg_d;
      outFlg_q <= outFlg_d;
      cmFlg_q <= cmFlg_d;
      inEn_q <= inEn_d;
      outEn_q <= outEn_d;
      cmEn_q <= cmEn_d;
      frame_q <= frame_d;
      isoHold_q <= isoWait_d;
      rstPrev_q <= rstPrev_d;
      sieRdData_q <= sieRdData_d;
      zlpSend_q <= zlp_d;
      irq_q <= irq_d;
      cpuWr_q <= cpuWr_d;
      cpuRd_q <= cpuRd_d;
      sieWp_q <= sieWp_d;
      sieRp_q <= sieRp_d;
    end
  end

  // ==========================================================
  // Buffer memory writes
  always_ff @(posedge clk) begin
    if (memCpuWe) begin
      mem[cpuWa] <= sfrWdata;
    end
    if (sieWr && !coreInhibit_q) begin
      mem[sieWa] <= sieWrData;
    end
  end

endmodule
`default_nettype wire

// *** tb/ufdc_host_model.sv ***
// Bus-side partner model driving host traffic events into the core
`timescale 1ns/10ps
`default_nettype none
// ====
// Host model
module ufdc_host_model (
  input wire logic clk,
  output logic busResetDet,
  output logic suspendDet,
  output logic resumeDet,
  output logic sofRx,
  output logic [10:0] sofFrame,
  output logic xferEnd,
  output logic inToken,
  output logic [1:0] tokenEp,
  output logic [3:0] inPktLoaded,
  output logic [3:0] inEpDone,
  output logic [3:0] outEpDone,
  output logic sieWr,
  output logic [1:0] sieWrEp,
  output logic [7:0] sieWrData,
  output logic sieRd,
  output logic [1:0] sieRdEp
);
  logic [7:0] hit = 8'h00;
  logic [10:0] val = 11'h000;
  logic [2:0] lvl = 3'h0;
  assign {busResetDet, suspendDet, resumeDet} = lvl;
  assign {sofRx, xferEnd, inToken, sieWr, sieRd} = {hit[0], hit[1], hit[2], hit[6], hit[7]};
  assign sofFrame = val;
  assign {tokenEp, sieRdEp} = {2{val[1:0]}};
  assign {sieWrEp, sieWrData} = val[9:0];
  assign inPktLoaded = hit[3] ? val[3:0] : 4'h0;
  assign inEpDone = hit[4] ? val[3:0] : 4'h0;
  assign outEpDone = hit[5] ? val[3:0] : 4'h0;
  // One-cycle event; qualifiers inverted once released
  task automatic pulse(input int k, input logic [10:0] v);
    @(posedge clk);
    hit <= 8'h01 << k;
    val <= v;
    @(posedge clk);
    hit <= 8'h00;
    val <= ~v;
  endtask
  task automatic level(input int k, input logic v);
    @(posedge clk);
    lvl[k] <= v;
  endtask
endmodule
`default_nettype wire

// *** tb/ufdc_core_chk.sv ***
// Port assertions of the USB function control core
`timescale 1ns/10ps
`default_nettype none
// ====
// Checker
module ufdc_core_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sfrSel,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata_q,
  input wire logic cpuIrqEn,
  input wire logic irq_q,
  input wire logic busResetDet,
  input wire logic suspendDet,
  input wire logic resumeDet,
  input wire logic sofRx,
  input wire logic xferEnd,
  input wire logic inToken,
  input wire logic [1:0] tokenEp,
  input wire logic [3:0] inPktLoaded,
  input wire logic [6:0] activeAddr_q,
  input wire logic coreInhibit_q,
  input wire logic resumeDrive_q,
  input wire logic suspendActive_q,
  input wire logic zlpSend_q,
  input wire logic [3:0] isoHold_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence heldTok;
    inToken && isoHold_q[tokenEp] && !coreInhibit_q;
  endsequence
  irq_gate_a: assert property (!cpuIrqEn ##1 !cpuIrqEn |-> !irq_q) else $error("irq while disabled");
  inh_rose_a: assert property ($rose(coreInhibit_q) |-> $past(sfrWr && sfrSel, 1) ||
    $past(sfrWr && sfrSel, 2) || $past(sfrWr && sfrSel, 3)) else $error("inhibit set without core reset");
  inh_fell_a: assert property ($fell(coreInhibit_q) |-> $past(sfrWr && sfrSel && !sfrWdata[4]))
    else $error("inhibit cleared without write");
  addr_defer_a: assert property ($changed(activeAddr_q) && activeAddr_q != 7'h00 |-> $past(xferEnd))
    else $error("address used early");
  susp_entry_a: assert property ($rose(suspendActive_q) |-> $past(suspendDet) && !$past(coreInhibit_q))
    else $error("suspend without cause");
  bus_exit_a: assert property ($rose(busResetDet) && !coreInhibit_q && !suspendDet |=> !suspendActive_q)
    else $error("suspend kept over bus reset");
  resume_exit_a: assert property (suspendActive_q && resumeDet && !suspendDet && !coreInhibit_q
    |=> !suspendActive_q) else $error("suspend kept over resume");
  wake_drive_a: assert property ($rose(resumeDrive_q) |-> $past(sfrWr && sfrSel && sfrWdata[2]))
    else $error("wakeup without write");
  zlp_cause_a: assert property (heldTok |=> zlpSend_q) else $error("no zero-length answer");
  zlp_only_a: assert property (zlpSend_q |-> $past(inToken)) else $error("stray zero-length answer");
  iso_set_a: assert property (|(isoHold_q & ~$past(isoHold_q)) |-> |$past(inPktLoaded))
    else $error("hold without packet");
  sof_release_a: assert property (sofRx && !coreInhibit_q && inPktLoaded == 4'h0 |=> isoHold_q == 4'h0)
    else $error("hold kept past frame start");
  rdata_hold_a: assert property (!$past(sfrRd) |-> $stable(sfrRdata_q))
    else $error("read data moved");
endmodule
bind ufdc_core ufdc_core_chk ufdc_core_chk_i (.clk, .rst_n, .sfrSel, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata_q,
  .cpuIrqEn, .irq_q, .busResetDet, .suspendDet, .resumeDet, .sofRx, .xferEnd, .inToken, .tokenEp, .inPktLoaded,
  .activeAddr_q, .coreInhibit_q, .resumeDrive_q, .suspendActive_q, .zlpSend_q, .isoHold_q);
`default_nettype wire

// *** tb/test_ufdc_core.sv ***
// Self-checking bench of the USB function control core
`timescale 1ns/10ps
`default_nettype none
`include "ufdc_defs.svh"
// ====
// Bench
module test_ufdc_core
  import ufdc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sfrSel = 1'b0;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic cpuIrqEn = 1'b0;
  ufdc_byte_t sfrWdata = 8'h00;
  logic [3:0] isoEp = 4'h0;
  logic [3:0] splitMode = 4'h0;
  ufdc_byte_t sfrRdata_q, sieWrData, sieRdData_q;
  logic irq_q, busResetDet, suspendDet, resumeDet, sofRx, xferEnd, inToken, sieWr, sieRd;
  logic coreInhibit_q, resumeDrive_q, suspendActive_q, zlpSend_q;
  logic [1:0] tokenEp, sieWrEp, sieRdEp;
  logic [3:0] inPktLoaded, inEpDone, outEpDone, isoHold_q;
  logic [10:0] sofFrame;
  logic [6:0] activeAddr_q;
  int nErrors = 0;
  int totalChecks = 0;
  int i;
  always #5 clk = ~clk;
  ufdc_core ufdc_core_i (.clk, .rst_n, .sfrSel, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata_q, .cpuIrqEn, .irq_q,
    .busResetDet, .suspendDet, .resumeDet, .sofRx, .sofFrame, .xferEnd, .inToken, .tokenEp, .isoEp,
    .inPktLoaded, .inEpDone, .outEpDone, .splitMode, .sieWr, .sieWrEp, .sieWrData, .sieRd, .sieRdEp,
    .sieRdData_q, .activeAddr_q, .coreInhibit_q, .resumeDrive_q, .suspendActive_q, .zlpSend_q, .isoHold_q);
  ufdc_host_model ufdc_host_model_i (.clk, .busResetDet, .suspendDet, .resumeDet, .sofRx, .sofFrame,
    .xferEnd, .inToken, .tokenEp, .inPktLoaded, .inEpDone, .outEpDone, .sieWr, .sieWrEp, .sieWrData,
    .sieRd, .sieRdEp);
  task automatic wrapUp;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ev(input int k, input logic [10:0] v);
    ufdc_host_model_i.pulse(k, v);
  endtask
  task automatic lv(input int k, input logic v);
    ufdc_host_model_i.level(k, v);
  endtask
  task automatic regWr(input logic [5:0] a, input ufdc_byte_t d);
    @(posedge clk);
    sfrSel <= 1'b0;
    sfrWr <= 1'b1;
    sfrWdata <= {2'b00, a};
    @(posedge clk);
    sfrSel <= 1'b1;
    sfrWdata <= d;
    @(posedge clk);
    sfrWr <= 1'b0;
  endtask
  // Indirect read: start, poll busy, then read the data port
  task automatic rdChk(input logic [5:0] a, input ufdc_byte_t exp);
    int n;
    @(posedge clk);
    sfrSel <= 1'b0;
    sfrWr <= 1'b1;
    sfrWdata <= {2'b10, a};
    @(posedge clk);
    sfrWr <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      sfrRd <= 1'b1;
      @(posedge clk);
      sfrRd <= 1'b0;
      @(negedge clk);
      n++;
    end while (sfrRdata_q[7] !== 1'b0 && n < 8);
    if (sfrRdata_q[7] !== 1'b0) begin
      nErrors++;
      wrapUp();
    end
    @(posedge clk);
    sfrSel <= 1'b1;
    sfrRd <= 1'b1;
    @(posedge clk);
    sfrRd <= 1'b0;
    @(negedge clk);
    chk(sfrRdata_q, exp);
  endtask
  task automatic scStart;
    chk(coreInhibit_q, 1'b1);
    rdChk(`UFDC_A_POWER, `UFDC_POWER_RST);
    ev(4, 11'h00f);
    rdChk(`UFDC_A_INFLG, 8'h00);
    rdChk(`UFDC_A_FRMH, 8'h00);
    rdChk(6'h3f, 8'h00);
    regWr(`UFDC_A_POWER, 8'h08);
    repeat (3) @(posedge clk);
    regWr(`UFDC_A_CMEN, 8'h07);
    regWr(`UFDC_A_POWER, 8'h01);
    @(negedge clk);
    chk(coreInhibit_q, 1'b0);
  endtask
  task automatic scFlags;
    ev(0, 11'h5a3);
    rdChk(`UFDC_A_FRML, 8'ha3);
    rdChk(`UFDC_A_FRMH, 8'h05);
    @(posedge clk);
    cpuIrqEn <= 1'b1;
    ev(4, 11'h00f);
    @(negedge clk);
    chk(irq_q, 1'b1);
    rdChk(`UFDC_A_INFLG, 8'h0f);
    rdChk(`UFDC_A_INFLG, 8'h00);
    ev(5, 11'h00f);
    rdChk(`UFDC_A_OUTFLG, 8'h0e);
    chk(irq_q, 1'b0);
  endtask
  task automatic scAddr;
    regWr(`UFDC_A_FUNCTION_ADDRESS, 8'h05);
    rdChk(`UFDC_A_FUNCTION_ADDRESS, 8'h85);
    chk(activeAddr_q, 7'h00);
    ev(1, 11'h000);
    rdChk(`UFDC_A_FUNCTION_ADDRESS, 8'h05);
    chk(activeAddr_q, 7'h05);
  endtask
  task automatic scFifo;
    for (i = 0; i < 65; i++)
      regWr({`UFDC_A_FIFO, 2'd0}, i[7:0]);
    ev(7, 11'h000);
    @(negedge clk);
    chk(sieRdData_q, 8'h40);
    ev(7, 11'h000);
    @(negedge clk);
    chk(sieRdData_q, 8'h01);
    @(posedge clk);
    splitMode <= 4'h4;
    regWr({`UFDC_A_FIFO, 2'd2}, 8'haa);
    ev(7, 11'h002);
    @(negedge clk);
    chk(sieRdData_q, 8'haa);
    ev(6, 11'h25b);
    rdChk({`UFDC_A_FIFO, 2'd2}, 8'h5b);
    ev(6, 11'h211);
    ev(6, 11'h222);
    // Auto-read: each data read starts the next fetch
    @(posedge clk);
    sfrSel <= 1'b0;
    sfrWr <= 1'b1;
    sfrWdata <= 8'he2;
    @(posedge clk);
    sfrWr <= 1'b0;
    repeat (2) @(posedge clk);
    sfrSel <= 1'b1;
    sfrRd <= 1'b1;
    @(posedge clk);
    sfrRd <= 1'b0;
    @(negedge clk);
    chk(sfrRdata_q, 8'h11);
    repeat (2) @(posedge clk);
    sfrRd <= 1'b1;
    @(posedge clk);
    sfrRd <= 1'b0;
    @(negedge clk);
    chk(sfrRdata_q, 8'h22);
  endtask
  task automatic scBusReset;
    lv(1, 1'b1);
    repeat (2) @(negedge clk);
    lv(1, 1'b0);
    lv(2, 1'b1);
    repeat (2) @(negedge clk);
    chk(activeAddr_q, 7'h00);
    chk(suspendActive_q, 1'b0);
    lv(2, 1'b0);
    rdChk(`UFDC_A_CMFLG, 8'h05);
    rdChk(`UFDC_A_FUNCTION_ADDRESS, 8'h00);
    rdChk(`UFDC_A_INEN, 8'h0f);
    regWr({`UFDC_A_FIFO, 2'd0}, 8'h3c);
    ev(7, 11'h000);
    @(negedge clk);
    chk(sieRdData_q, 8'h3c);
  endtask
  task automatic scSuspend;
    lv(1, 1'b1);
    repeat (2) @(negedge clk);
    chk(suspendActive_q, 1'b1);
    lv(1, 1'b0);
    rdChk(`UFDC_A_CMFLG, 8'h01);
    lv(0, 1'b1);
    repeat (2) @(negedge clk);
    chk(suspendActive_q, 1'b0);
    lv(0, 1'b0);
    rdChk(`UFDC_A_CMFLG, 8'h02);
    lv(1, 1'b1);
    repeat (2) @(negedge clk);
    chk(suspendActive_q, 1'b1);
    lv(1, 1'b0);
    regWr(`UFDC_A_POWER, 8'h05);
    @(negedge clk);
    chk(resumeDrive_q, 1'b1);
    regWr(`UFDC_A_POWER, 8'h01);
    @(negedge clk);
    chk(resumeDrive_q, 1'b0);
    chk(suspendActive_q, 1'b0);
  endtask
  task automatic scIso;
    @(posedge clk);
    isoEp <= 4'h2;
    regWr(`UFDC_A_POWER, 8'h81);
    ev(3, 11'h002);
    @(negedge clk);
    chk(isoHold_q, 4'h2);
    ev(2, 11'h001);
    @(negedge clk);
    chk(zlpSend_q, 1'b1);
    ev(0, 11'h010);
    @(negedge clk);
    chk(isoHold_q, 4'h0);
    regWr(`UFDC_A_POWER, 8'h08);
    repeat (3) @(posedge clk);
    chk(coreInhibit_q, 1'b1);
    rdChk(`UFDC_A_POWER, `UFDC_POWER_RST);
    rdChk(`UFDC_A_CMEN, 8'h06);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    scStart();
    scFlags();
    scAddr();
    scFifo();
    scBusReset();
    scSuspend();
    scIso();
    wrapUp();
  end
endmodule
`default_nettype wire
